/* File: hdl/rmd_pkg.sv */
// Constants and types for the return and misc opcode decoder
package rmd_pkg;
    localparam int RMD_WORD_W = 14;
    localparam int RMD_DATA_W = 8;
    localparam int RMD_PC_W = 13;
    localparam int RMD_JUMP_K_W = 11;
    localparam int RMD_LIT_W = 8;
    // Fixed encodings
    localparam logic [13:0] RMD_ENC_RETFI = 14'h0009;
    localparam logic [13:0] RMD_ENC_LDOPT = 14'h0062;
    // No-operation: 00 0000 0xx0 0000, x bits masked out
    localparam logic [13:0] RMD_NOOP_MASK = 14'h3F9F;
    localparam logic [13:0] RMD_NOOP_VAL = 14'h0000;
    // Return with literal: 11 01xx kkkk kkkk
    localparam logic [13:0] RMD_RETLIT_MASK = 14'h3C00;
    localparam logic [13:0] RMD_RETLIT_VAL = 14'h3400;
    // Interrupt control register bit position of the global enable
    localparam int RMD_GLOBAL_EN_BIT = 7;
    // Oscillator periods per instruction cycle
    localparam int RMD_OSC_PER_CYC = 4;
    localparam logic [7:0] RMD_OPTION_RST = 8'hFF;
    localparam logic [7:0] RMD_INT_CTRL_RST = 8'h00;
    localparam logic [7:0] RMD_W_RST = 8'h00;

    typedef enum logic [1:0] {
        RMD_ST_EXEC = 2'b01,
        RMD_ST_IDLE = 2'b10
    } rmd_state_t;
endpackage : rmd_pkg

/* File: hdl/rmd_decoder.sv */
// Decode and execute of no-op, returns, load-option and jump literal
`timescale 1ns/1ps
// Function
// - Jump/call format takes low 11 bits as immediate target.
// - Return-from-interrupt pops stack, loads top entry into PC.
// - Return-from-interrupt sets global interrupt enable, control bit 7.
// - Return-from-interrupt is one word, two cycles, second idle.
// - Load-option copies working register into option register.
// - Return-with-literal loads its 8-bit literal into working register.
// - Return-with-literal pops stack and loads return address into PC.
// - Return-with-literal is one word, two cycles.
// - Instruction cycle is four oscillator periods; PC changes take two.
module rmd_decoder
    import rmd_pkg::*;
#(
    parameter int OSC_PER_CYC = RMD_OSC_PER_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Instruction fetch
    input wire logic [RMD_WORD_W-1:0] i_instr,
    input wire logic i_instr_valid,
    // Core state in
    input wire logic [RMD_PC_W-1:0] i_stack_top_entry,
    input wire logic [RMD_DATA_W-1:0] i_w_wr_data,
    input wire logic i_w_wr,
    input wire logic [RMD_DATA_W-1:0] i_int_ctrl_wr_data,
    input wire logic i_int_ctrl_wr,
    input wire logic [RMD_DATA_W-1:0] i_option_wr_data,
    input wire logic i_option_wr,
    // Decode results
    output logic o_instr_cycle,
    output logic o_fetch_ready,
    output logic o_stack_pop,
    output logic o_pc_load,
    output logic [RMD_PC_W-1:0] o_pc_value,
    output logic [RMD_JUMP_K_W-1:0] o_jump_target,
    output logic o_no_operation_instr,
    output logic o_return_from_interrupt_instr,
    output logic o_return_with_literal_instr,
    output logic o_load_option_instr,
    output logic o_idle_cycle,
    // Core registers
    output logic [RMD_DATA_W-1:0] o_w,
    output logic [RMD_DATA_W-1:0] o_interrupt_control_register,
    output logic o_global_interrupt_enable,
    output logic [RMD_DATA_W-1:0] o_option
);

    function automatic logic match(input logic [13:0] word,
                                   input logic [13:0] mask,
                                   input logic [13:0] val);
        match = (word & mask) == val;
    endfunction : match

    // ------------------------------------------------------------
    // Instruction cycle divider
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;

    always_comb begin
        if (div_cnt == 8'(OSC_PER_CYC - 1)) begin
            next_div_cnt = 8'h00;
        end else begin
            next_div_cnt = div_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    logic cyc;
    assign cyc = (div_cnt == 8'(OSC_PER_CYC - 1));
    assign o_instr_cycle = cyc;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic dec_noop;
    logic dec_retfi;
    logic dec_ldopt;
    logic dec_retlit;
    rmd_state_t state;
    rmd_state_t next_state;

    assign dec_noop = match(i_instr, RMD_NOOP_MASK, RMD_NOOP_VAL);
    assign dec_retfi = match(i_instr, 14'h3FFF, RMD_ENC_RETFI);
    assign dec_ldopt = match(i_instr, 14'h3FFF, RMD_ENC_LDOPT);
    assign dec_retlit = match(i_instr, RMD_RETLIT_MASK,
                              RMD_RETLIT_VAL);

    logic exec;
    assign exec = cyc && i_instr_valid && (state == RMD_ST_EXEC);
    assign o_fetch_ready = (state == RMD_ST_EXEC);

    // ------------------------------------------------------------
    // Sequencer and registered outputs
    // ------------------------------------------------------------
    logic [RMD_DATA_W-1:0] w_q;
    logic [RMD_DATA_W-1:0] next_w_q;
    logic [RMD_DATA_W-1:0] int_ctrl_q;
    logic [RMD_DATA_W-1:0] next_int_ctrl_q;
    logic [RMD_DATA_W-1:0] option_q;
    logic [RMD_DATA_W-1:0] next_option_q;
    logic pop_q, next_pop_q;
    logic pcld_q, next_pcld_q;
    logic [RMD_PC_W-1:0] pc_q, next_pc_q;
    logic [RMD_JUMP_K_W-1:0] jt_q, next_jt_q;
    logic [4:0] kind_q, next_kind_q;

    always_comb begin
        next_state = state;
        next_w_q = w_q;
        next_int_ctrl_q = int_ctrl_q;
        next_option_q = option_q;
        next_pop_q = 1'b0;
        next_pcld_q = 1'b0;
        next_pc_q = pc_q;
        next_jt_q = jt_q;
        next_kind_q = 5'h00;
        // Core-side writes first so decoded effects win in the same cycle
        if (i_w_wr) begin
            next_w_q = i_w_wr_data;
        end
        if (i_int_ctrl_wr) begin
            next_int_ctrl_q = i_int_ctrl_wr_data;
        end
        if (i_option_wr) begin
            next_option_q = i_option_wr_data;
        end
        case (state)
            RMD_ST_EXEC: begin
                if (exec) begin
                    next_jt_q = i_instr[RMD_JUMP_K_W-1:0];
                    if (dec_retfi) begin
                        next_pop_q = 1'b1;
                        next_pcld_q = 1'b1;
                        next_pc_q = i_stack_top_entry;
                        next_int_ctrl_q[RMD_GLOBAL_EN_BIT] = 1'b1;
                        next_kind_q[1] = 1'b1;
                        next_state = RMD_ST_IDLE;
                    end else if (dec_retlit) begin
                        next_w_q = i_instr[RMD_LIT_W-1:0];
                        next_pop_q = 1'b1;
                        next_pcld_q = 1'b1;
                        next_pc_q = i_stack_top_entry;
                        next_kind_q[2] = 1'b1;
                        next_state = RMD_ST_IDLE;
                    end else if (dec_ldopt) begin
                        // Kept for old code; software should write it direct
                        next_option_q = w_q;
                        next_kind_q[3] = 1'b1;
                    end else if (dec_noop) begin
                        next_kind_q[0] = 1'b1;
                    end
                end
            end
            RMD_ST_IDLE: begin
                if (cyc) begin
                    // Second cycle of a PC change acts as a no-op
                    next_kind_q[4] = 1'b1;
                    next_state = RMD_ST_EXEC;
                end
            end
            default: begin
                next_state = RMD_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= RMD_ST_EXEC;
            w_q <= RMD_W_RST;
            int_ctrl_q <= RMD_INT_CTRL_RST;
            option_q <= RMD_OPTION_RST;
            pop_q <= 1'b0;
            pcld_q <= 1'b0;
            pc_q <= '0;
            jt_q <= '0;
            kind_q <= 5'h00;
        end else begin
            state <= next_state;
            w_q <= next_w_q;
            int_ctrl_q <= next_int_ctrl_q;
            option_q <= next_option_q;
            pop_q <= next_pop_q;
            pcld_q <= next_pcld_q;
            pc_q <= next_pc_q;
            jt_q <= next_jt_q;
            kind_q <= next_kind_q;
        end
    end

    // ------------------------------------------------------------
    // Output map
    // ------------------------------------------------------------
    assign o_stack_pop = pop_q;
    assign o_pc_load = pcld_q;
    assign o_pc_value = pc_q;
    assign o_jump_target = jt_q;
    assign o_no_operation_instr = kind_q[0];
    assign o_return_from_interrupt_instr = kind_q[1];
    assign o_return_with_literal_instr = kind_q[2];
    assign o_load_option_instr = kind_q[3];
    assign o_idle_cycle = kind_q[4];
    assign o_w = w_q;
    assign o_interrupt_control_register = int_ctrl_q;
    assign o_global_interrupt_enable = int_ctrl_q[RMD_GLOBAL_EN_BIT];
    assign o_option = option_q;

endmodule : rmd_decoder

/* File: test/rmd_decoder_props.sv */
// Checker for the return and misc opcode decoder
`timescale 1ns/1ps
module rmd_decoder_props
    import rmd_pkg::*;
#(
    parameter int OSC_PER_CYC = RMD_OSC_PER_CYC
) (
    // Clock, reset and fetch
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [RMD_WORD_W-1:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic [RMD_PC_W-1:0] i_stack_top_entry,
    // Results
    input wire logic o_instr_cycle,
    input wire logic o_fetch_ready,
    input wire logic o_stack_pop,
    input wire logic o_pc_load,
    input wire logic [RMD_PC_W-1:0] o_pc_value,
    input wire logic [RMD_JUMP_K_W-1:0] o_jump_target,
    input wire logic o_return_from_interrupt_instr,
    input wire logic o_return_with_literal_instr,
    input wire logic o_load_option_instr,
    input wire logic o_idle_cycle,
    input wire logic [RMD_DATA_W-1:0] o_w,
    input wire logic o_global_interrupt_enable,
    input wire logic [RMD_DATA_W-1:0] o_option
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire tk = i_instr_valid && o_instr_cycle && o_fetch_ready;
    wire lit = tk && ((i_instr & RMD_RETLIT_MASK) == RMD_RETLIT_VAL);
    wire rfi = tk && (i_instr == RMD_ENC_RETFI);
    int gap;
    int next_gap;
    always_comb begin
        next_gap = o_instr_cycle ? 0 : gap + 1;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            gap <= 0;
        end else begin
            gap <= next_gap;
        end
    end
    jump_field_a:
        assert property (tk |=> o_jump_target == $past(i_instr[10:0]))
        else $error("Jump target wrong");
    pop_load_a:
        assert property ((rfi || lit) |=> o_stack_pop && o_pc_load
            && o_pc_value == $past(i_stack_top_entry))
        else $error("Stack pop or pc load wrong");
    global_en_set_a:
        assert property (rfi |=> o_global_interrupt_enable)
        else $error("Global enable not set");
    lit_to_w_a:
        assert property (lit |=> o_w == $past(i_instr[7:0]))
        else $error("Literal not in working register");
    opt_copy_a:
        assert property (tk && i_instr == RMD_ENC_LDOPT |=>
            o_option == $past(o_w) && o_load_option_instr && o_fetch_ready)
        else $error("Option copy wrong");
    noop_keep_a:
        assert property (tk && (i_instr & RMD_NOOP_MASK) == RMD_NOOP_VAL |=>
            o_fetch_ready && $stable(o_w) && $stable(o_option))
        else $error("No-op changed state");
    ret_idle_a:
        assert property (o_return_from_interrupt_instr
            || o_return_with_literal_instr |->
            !o_fetch_ready ##4 (o_idle_cycle && o_fetch_ready))
        else $error("Idle second cycle wrong");
    cyc_period_a:
        assert property (o_instr_cycle == (gap == OSC_PER_CYC - 1))
        else $error("Instruction cycle spacing wrong");
endmodule : rmd_decoder_props

bind rmd_decoder rmd_decoder_props #(.OSC_PER_CYC(OSC_PER_CYC)) chk_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
    .i_instr_valid(i_instr_valid), .i_stack_top_entry(i_stack_top_entry),
    .o_instr_cycle(o_instr_cycle), .o_fetch_ready(o_fetch_ready),
    .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_jump_target(o_jump_target),
    .o_return_from_interrupt_instr(o_return_from_interrupt_instr),
    .o_return_with_literal_instr(o_return_with_literal_instr),
    .o_load_option_instr(o_load_option_instr), .o_idle_cycle(o_idle_cycle),
    .o_w(o_w), .o_global_interrupt_enable(o_global_interrupt_enable),
    .o_option(o_option));

/* File: test/tb_top.sv */
// Self-checking bench for the return and misc opcode decoder
`timescale 1ns/1ps
module tb_top;
    import rmd_pkg::*;
    typedef struct {
        logic [13:0] ins;
        logic [12:0] top;
        logic [7:0] ew;
        logic [7:0] eo;
        logic pop;
        logic [3:0] pls;
    } rmd_row_t;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_instr_valid = 1'b0, i_w_wr = 1'b0;
    logic i_int_ctrl_wr = 1'b0, i_option_wr = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [12:0] i_stack_top_entry = 13'h0000;
    logic [7:0] w_d = 8'h00, ic_d = 8'h00, op_d = 8'h00;
    logic cyc, rdy, pop, pcl, noopi, rfi, rli, ldo, idle, gen;
    logic [12:0] pcv;
    logic [10:0] jt;
    logic [7:0] w, ic, opt;
    int bad_count = 0;
    int n_checks = 0;
    int gap;
    int span;
    // Pulse column is {load-option, ret-interrupt, ret-literal, no-op}
    rmd_row_t rows [8] = '{
        '{14'h3455, 13'h0123, 8'h55, 8'hFF, 1'b1, 4'h2},
        '{14'h0062, 13'h0000, 8'h55, 8'h55, 1'b0, 4'h8},
        '{14'h0060, 13'h0000, 8'h55, 8'h55, 1'b0, 4'h1},
        '{14'h37FF, 13'h1FFF, 8'hFF, 8'h55, 1'b1, 4'h2},
        '{14'h3400, 13'h0000, 8'h00, 8'h55, 1'b1, 4'h2},
        '{14'h0062, 13'h0000, 8'h00, 8'h00, 1'b0, 4'h8},
        '{14'h2ABC, 13'h0000, 8'h00, 8'h00, 1'b0, 4'h0},
        '{14'h0020, 13'h0000, 8'h00, 8'h00, 1'b0, 4'h1}};
    always #4 i_clk = ~i_clk;
    rmd_decoder dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
        .i_instr_valid(i_instr_valid), .i_stack_top_entry(i_stack_top_entry),
        .i_w_wr_data(w_d), .i_w_wr(i_w_wr), .i_int_ctrl_wr_data(ic_d),
        .i_int_ctrl_wr(i_int_ctrl_wr), .i_option_wr_data(op_d),
        .i_option_wr(i_option_wr), .o_instr_cycle(cyc), .o_fetch_ready(rdy),
        .o_stack_pop(pop), .o_pc_load(pcl), .o_pc_value(pcv),
        .o_jump_target(jt), .o_no_operation_instr(noopi),
        .o_return_from_interrupt_instr(rfi),
        .o_return_with_literal_instr(rli), .o_load_option_instr(ldo),
        .o_idle_cycle(idle), .o_w(w), .o_interrupt_control_register(ic),
        .o_global_interrupt_enable(gen), .o_option(opt));
    task chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // Counts edges until a word can be offered
    task slot();
        gap = 0;
        do begin
            @(posedge i_clk);
            #1;
            gap++;
        end while (!(cyc === 1'b1 && rdy === 1'b1) && gap < 50);
        chk(cyc === 1'b1 && rdy === 1'b1, "no slot");
    endtask : slot
    task issue(input logic [13:0] v);
        i_instr = v;
        i_instr_valid = 1'b1;
        @(posedge i_clk);
        #1;
        i_instr_valid = 1'b0;
    endtask : issue
    task tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        chk(opt === RMD_OPTION_RST && w === 8'h00 && ic === 8'h00, "reset");
        slot();
        foreach (rows[k]) begin
            i_stack_top_entry = rows[k].top;
            span = RMD_OSC_PER_CYC * (rows[k].pop ? 2 : 1);
            issue(rows[k].ins);
            chk(w === rows[k].ew, "working reg");
            chk(opt === rows[k].eo, "option reg");
            chk(jt === rows[k].ins[10:0], "jump field");
            chk(pop === rows[k].pop, "pop");
            chk(pcl === rows[k].pop, "pc load");
            if (rows[k].pop) chk(pcv === rows[k].top, "pc value");
            chk({ldo, rfi, rli, noopi} === rows[k].pls, "kind");
            slot();
            chk(gap + 1 === span, "cycles");
        end
        // Same-edge interrupt_control_register clear must lose to the return
        i_stack_top_entry = 13'h0AAA;
        i_int_ctrl_wr = 1'b1;
        issue(RMD_ENC_RETFI);
        i_int_ctrl_wr = 1'b0;
        chk(gen === 1'b1 && ic === 8'h80 && rfi === 1'b1, "enable");
        chk(pcv === 13'h0AAA && pop === 1'b1, "return pc");
        @(posedge i_clk);
        #1;
        i_instr = 14'h3433;
        i_instr_valid = 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        i_instr_valid = 1'b0;
        chk(w === 8'h00, "word taken in idle cycle");
        // Option written directly by address, then by copy
        w_d = 8'hA5;
        op_d = 8'h3C;
        i_w_wr = 1'b1;
        i_option_wr = 1'b1;
        @(posedge i_clk);
        #1;
        i_w_wr = 1'b0;
        i_option_wr = 1'b0;
        chk(opt === 8'h3C && w === 8'hA5, "core writes");
        slot();
        issue(RMD_ENC_LDOPT);
        chk(opt === 8'hA5 && ldo === 1'b1, "option copy");
        i_rst = 1'b1;
        #1;
        chk(opt === 8'hFF && gen === 1'b0 && rdy === 1'b1, "mid reset");
        @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        slot();
        chk(gap + 1 === RMD_OSC_PER_CYC, "restart");
        tally_and_finish();
    end
endmodule : tb_top
